// *** hdl/aux_result_polarity_cfg.sv ***
// Auxiliary results for channels four and five, cell input range control
// and auxiliary reference control, behind an AHB-Lite slave.
// Assumes the scan sequencer delivers results as one-cycle strobes.
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module aux_result_polarity_cfg
    import aux_cfg_pkg::*;
(
    input wire logic ref_clk,                     // 25 MHz clock
    input wire logic resetn,                      // Async reset, active low
    input wire logic hsel,                        // AHB select
    input wire logic [31:0] haddr,                // AHB address
    input wire logic [1:0] htrans,                // AHB transfer type
    input wire logic hwrite,                      // AHB write
    input wire logic [2:0] hsize,                 // AHB size
    input wire logic [31:0] hwdata,               // AHB write data
    input wire logic hready,                      // AHB ready in
    output logic hreadyout,                       // AHB ready out
    output logic hresp,                           // AHB response
    output logic [31:0] hrdata,                   // AHB read data
    input wire logic aux_result_valid,            // Result strobe
    input wire logic aux_result_sel,              // 0 channel four, 1 five
    input wire logic aux_result_skipped,          // Channel skipped this scan
    input wire logic [13:0] aux_channel_result,   // Conversion value
    input wire logic aux_measure_enable,          // Aux measurement enable
    input wire logic [5:0] aux_pin_function_config, // 1 = analog input
    input wire logic [5:0] pin_io_mode_enable,    // 1 = pin in I/O mode
    output logic [5:0] aux_reference_select,      // 1 = absolute reference
    input wire logic balance_switch_diagnostic,   // Diagnostic scan running
    input wire logic [13:0] cell_fault_raw,       // Raw per-cell faults
    output logic [13:0] cell_bipolar,             // Polarity per cell
    output logic [13:0] extremes_include,         // Cells in min/max/mismatch
    output logic [13:0] bipolar_threshold_sel,    // Bipolar thresholds used
    output logic [13:0] comparator_scan_enable,   // Cells in comparator scan
    output logic [13:0] cell_fault_masked         // Masked faults
);
    import aux_cfg_pkg::*;

    reg_access_if acc ();

    logic [13:0] aux_result_four_r;
    logic [13:0] aux_result_five_r;
    logic [13:0] polarity_r;
    logic extremes_sel_r;
    logic [5:0] aux_ref_r;
    logic result_update;

    ahb_reg_port u_port (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .acc(acc.port)
    );

    assign result_update = aux_result_valid && (aux_measure_enable || !aux_result_skipped);

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            aux_result_four_r <= RESULT_RESET[RESULT_W-1:0];
            aux_result_five_r <= RESULT_RESET[RESULT_W-1:0];
        end else if (result_update) begin
            if (aux_result_sel) begin
                aux_result_five_r <= aux_channel_result;
            end else begin
                aux_result_four_r <= aux_channel_result;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            polarity_r <= POLARITY_RESET;
            extremes_sel_r <= EXTREMES_SEL_RESET;
        end else if (acc.wr_en && acc.index == IDX_CELL_RANGE_CTRL) begin
            polarity_r <= acc.wdata[CELL_COUNT-1:0];
            extremes_sel_r <= acc.wdata[EXTREMES_SEL_BIT];
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            aux_ref_r <= AUX_REF_RESET;
        end else if (acc.wr_en && acc.index == IDX_AUX_REF_CTRL) begin
            aux_ref_r <= acc.wdata[AUX_REF_W-1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            aux_reference_select <= AUX_REF_RESET;
        end else begin
            aux_reference_select <= aux_ref_r & ~pin_io_mode_enable;
        end
    end

    // Read mux; result fields shifted up, low bits zero
    always_comb begin
        acc.rdata = 16'h0000;
        case (acc.index)
            IDX_AUX_RESULT_CH4: begin
                if (aux_pin_function_config[AUX_CH4]) begin
                    acc.rdata = {aux_result_four_r, 2'h0};
                end
            end
            IDX_AUX_RESULT_CH5: begin
                if (aux_pin_function_config[AUX_CH5]) begin
                    acc.rdata = {aux_result_five_r, 2'h0};
                end
            end
            IDX_CELL_RANGE_CTRL: acc.rdata = {extremes_sel_r, 1'b0, polarity_r};
            IDX_AUX_REF_CTRL: acc.rdata = {10'h000, aux_ref_r};
            default: acc.rdata = 16'h0000;
        endcase
    end

    assign cell_bipolar = polarity_r;

    cell_classify u_classify (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .cell_bipolar(polarity_r),
        .extremes_cell_type_select(extremes_sel_r),
        .balance_switch_diagnostic(balance_switch_diagnostic),
        .cell_fault_raw(cell_fault_raw),
        .extremes_include(extremes_include),
        .bipolar_threshold_sel(bipolar_threshold_sel),
        .comparator_scan_enable(comparator_scan_enable),
        .cell_fault_masked(cell_fault_masked)
    );

    logic unused_ok;
    assign unused_ok = ^{acc.rd_en, aux_pin_function_config[3:0]};
endmodule

`default_nettype wire

// *** hdl/aux_cfg_pkg.sv ***
// Register map, field layout and reset values of the auxiliary result
// and cell polarity register slice.
// Assumes a word-aligned AHB-Lite map: byte address is four times the index.
`default_nettype none

package aux_cfg_pkg;

    localparam int unsigned DATA_W = 16;
    localparam int unsigned INDEX_W = 8;

    // Register indices; byte address = index * 4
    localparam logic [7:0] IDX_AUX_RESULT_CH4 = 8'h5D;
    localparam logic [7:0] IDX_AUX_RESULT_CH5 = 8'h5E;
    localparam logic [7:0] IDX_CELL_RANGE_CTRL = 8'h5F;
    localparam logic [7:0] IDX_AUX_REF_CTRL = 8'h60;

    // Result field
    localparam int unsigned RESULT_LSB = 2;
    localparam int unsigned RESULT_W = 14;
    localparam logic [15:0] RESULT_RESET = 16'h0000;

    // Cell input range control fields
    localparam int unsigned CELL_COUNT = 14;
    localparam int unsigned EXTREMES_SEL_BIT = 15;
    localparam logic [13:0] POLARITY_RESET = 14'h0000;
    localparam logic EXTREMES_SEL_RESET = 1'b0;

    // Auxiliary reference control field
    localparam int unsigned AUX_REF_W = 6;
    localparam logic [5:0] AUX_REF_RESET = 6'h00;

    // Auxiliary channel positions inside the six-channel vectors
    localparam int unsigned AUX_CH4 = 4;
    localparam int unsigned AUX_CH5 = 5;
    localparam int unsigned AUX_CH_COUNT = 6;

    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    // Maps a byte address to a register index; flags misaligned or out of range
    function automatic logic addr_in_map(input logic [31:0] addr);
        return (addr[1:0] == 2'h0) && (addr[31:10] == 22'h000000);
    endfunction

    function automatic logic [7:0] addr_to_index(input logic [31:0] addr);
        return addr[9:2];
    endfunction

endpackage

`default_nettype wire

// *** hdl/reg_access_if.sv ***
// Internal register access carrier between the bus port and the
// register file; one-cycle strobes, read data combinational.
`timescale 1ns/10ps
`default_nettype none

interface reg_access_if;
    logic wr_en;
    logic rd_en;
    logic [7:0] index;
    logic [15:0] wdata;
    logic [15:0] rdata;

    modport port (output wr_en, output rd_en, output index, output wdata, input rdata);
    modport regs (input wr_en, input rd_en, input index, input wdata, output rdata);
endinterface

`default_nettype wire

// *** hdl/ahb_reg_port.sv ***
// AHB-Lite slave front end: zero wait states, always OKAY.
// Assumes single word transfers; narrower sizes are treated as word access.
`timescale 1ns/10ps
`default_nettype none

module ahb_reg_port
    import aux_cfg_pkg::*;
(
    input wire logic ref_clk,           // System clock
    input wire logic resetn,            // Async reset, active low
    input wire logic hsel,              // Slave select
    input wire logic [31:0] haddr,      // Byte address
    input wire logic [1:0] htrans,      // Transfer type
    input wire logic hwrite,            // Write when high
    input wire logic [2:0] hsize,       // Transfer size, unused
    input wire logic [31:0] hwdata,     // Write data
    input wire logic hready,            // Bus ready
    output logic hreadyout,             // Slave ready
    output logic hresp,                 // Response
    output logic [31:0] hrdata,         // Read data
    reg_access_if.port acc              // Register file side
);
    logic wr_pend_r;
    logic [7:0] wr_index_r;
    logic take;
    logic hit;

    assign take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);
    assign hit = addr_in_map(haddr);
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;

    // Write lands in the data phase, when hwdata is valid
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wr_pend_r <= 1'b0;
            wr_index_r <= 8'h00;
        end else begin
            wr_pend_r <= take && hwrite && hit;
            wr_index_r <= addr_to_index(haddr);
        end
    end

    assign acc.wr_en = wr_pend_r;
    assign acc.wdata = hwdata[15:0];
    assign acc.rd_en = take && !hwrite && hit;
    assign acc.index = acc.wr_en ? wr_index_r : addr_to_index(haddr);

    // Read data sampled at the address phase; unmapped reads give zero
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            hrdata <= 32'h00000000;
        end else if (take && !hwrite) begin
            hrdata <= (acc.rd_en && !acc.wr_en) ? {16'h0000, acc.rdata} : 32'h00000000;
        end
    end

    logic unused_ok;
    assign unused_ok = ^{hsize, hwdata[31:16]};
endmodule

`default_nettype wire

// *** hdl/cell_classify.sv ***
// Per-cell routing of polarity settings into the scan and alert logic.
// Assumes the fault vector and diagnostic flag are from the same scan.
`timescale 1ns/10ps
`default_nettype none

module cell_classify
    import aux_cfg_pkg::*;
(
    input wire logic ref_clk,                   // System clock
    input wire logic resetn,                    // Async reset, active low
    input wire logic [13:0] cell_bipolar,       // Polarity select per cell
    input wire logic extremes_cell_type_select, // Extremes use bipolar cells
    input wire logic balance_switch_diagnostic, // Diagnostic scan running
    input wire logic [13:0] cell_fault_raw,     // Raw per-cell faults
    output logic [13:0] extremes_include,       // Cells in min/max/mismatch
    output logic [13:0] bipolar_threshold_sel,  // Use bipolar thresholds
    output logic [13:0] comparator_scan_enable, // Cells in comparator scans
    output logic [13:0] cell_fault_masked       // Faults after masking
);
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            extremes_include <= 14'h0000;
            bipolar_threshold_sel <= 14'h0000;
            comparator_scan_enable <= 14'h0000;
        end else begin
            extremes_include <= extremes_cell_type_select ? cell_bipolar : ~cell_bipolar;
            bipolar_threshold_sel <= cell_bipolar;
            comparator_scan_enable <= ~cell_bipolar;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cell_fault_masked <= 14'h0000;
        end else begin
            cell_fault_masked <= balance_switch_diagnostic ?
                                 (cell_fault_raw & ~cell_bipolar) : cell_fault_raw;
        end
    end
endmodule

`default_nettype wire

// *** tb/aux_cfg_props.sv ***
// Checker for the aux result and polarity slice; sees top ports only.
// Assumes one clock domain; bound into the top at the foot of this file.
`timescale 1ns/10ps
`default_nettype none

module aux_cfg_props
    import aux_cfg_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic resetn, // Reset
    input wire logic hsel, // Bus
    input wire logic [31:0] haddr, // Bus
    input wire logic [1:0] htrans, // Bus
    input wire logic hwrite, // Bus
    input wire logic hready, // Bus
    input wire logic hreadyout, // Bus
    input wire logic hresp, // Bus
    input wire logic [31:0] hrdata, // Bus
    input wire logic [5:0] aux_pin_function_config, // Aux
    input wire logic [5:0] pin_io_mode_enable, // Aux
    input wire logic [5:0] aux_reference_select, // Aux
    input wire logic balance_switch_diagnostic, // Cells
    input wire logic [13:0] cell_fault_raw, // Cells
    input wire logic [13:0] cell_bipolar, // Cells
    input wire logic [13:0] extremes_include, // Cells
    input wire logic [13:0] bipolar_threshold_sel, // Cells
    input wire logic [13:0] comparator_scan_enable, // Cells
    input wire logic [13:0] cell_fault_masked // Cells
);
    import aux_cfg_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic rd_any;
    logic rd_ch4;
    assign rd_any = hsel && hready && htrans[1] && !hwrite;
    assign rd_ch4 = rd_any && haddr == {22'h000000, IDX_AUX_RESULT_CH4, 2'h0};

    a_bus_ready_okay: assert property (hreadyout && hresp == HRESP_OKAY)
        else $error("slave stalled or not okay");
    a_result_low_zero: assert property (rd_ch4 |=> hrdata[1:0] == 2'h0)
        else $error("result low bits not zero");
    a_unused_reads_zero: assert property (
        rd_ch4 && !aux_pin_function_config[AUX_CH4] ##1 1'b1 |-> hrdata == 32'h0)
        else $error("non-analog channel read not zero");
    a_rdata_holds: assert property (!rd_any |=> $stable(hrdata))
        else $error("read data moved without a read");
    a_extremes_mask: assert property (
        (extremes_include ^ $past(cell_bipolar)) inside {14'h0000, 14'h3FFF})
        else $error("extremes mask not polarity or inverse");
    a_bip_threshold: assert property (bipolar_threshold_sel == $past(cell_bipolar))
        else $error("threshold select not polarity");
    // Mask only follows polarity from the second edge after reset release
    a_comp_excluded: assert property (
        $past(resetn) |-> comparator_scan_enable == ~$past(cell_bipolar))
        else $error("bipolar cell in comparator scan");
    a_diag_masking: assert property (cell_fault_masked == ($past(balance_switch_diagnostic) ?
        $past(cell_fault_raw) & ~$past(cell_bipolar) : $past(cell_fault_raw)))
        else $error("fault masking wrong");
    a_io_mode_ignores: assert property ((aux_reference_select & $past(pin_io_mode_enable)) == 6'h00)
        else $error("reference select active in pin mode");

    c_read_ch4: cover property (rd_ch4 && aux_pin_function_config[AUX_CH4]);
    c_diag_bipolar: cover property (balance_switch_diagnostic && |cell_bipolar);
    c_abs_ref: cover property (|aux_reference_select);
endmodule

bind aux_result_polarity_cfg aux_cfg_props props_inst (.ref_clk, .resetn, .hsel, .haddr,
    .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .aux_pin_function_config,
    .pin_io_mode_enable, .aux_reference_select, .balance_switch_diagnostic, .cell_fault_raw,
    .cell_bipolar, .extremes_include, .bipolar_threshold_sel, .comparator_scan_enable,
    .cell_fault_masked);

`default_nettype wire

// *** tb/ahb_host.sv ***
// Host side bus master model: single word transfers only.
// Assumes xfer is entered right after a rising edge.
`timescale 1ns/10ps
`default_nettype none

module ahb_host
    import aux_cfg_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic hready, // Bus ready
    input wire logic [31:0] hrdata, // Read data
    output logic hsel, // Select
    output logic [31:0] haddr, // Address
    output logic [1:0] htrans, // Transfer type
    output logic hwrite, // Write
    output logic [2:0] hsize, // Size
    output logic [31:0] hwdata // Write data
);
    import aux_cfg_pkg::*;
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        haddr <= a;
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        hsel <= 1'b1;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        // Unused write data toggles so stale values never look valid
        hwdata <= wr ? wd : ~hwdata;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        rd = hrdata;
    endtask
endmodule

`default_nettype wire

// *** tb/tb_aux_result_polarity_cfg.sv ***
// Self-checking bench for the aux result and polarity slice.
// Assumes the host model drives the bus; bench drives scan side inputs.
`timescale 1ns/10ps
`default_nettype none

module tb_aux_result_polarity_cfg;
    import aux_cfg_pkg::*;
    logic ref_clk, resetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic aux_result_valid, aux_result_sel, aux_result_skipped, aux_measure_enable;
    logic balance_switch_diagnostic;
    logic [13:0] aux_channel_result, cell_fault_raw, cell_bipolar, extremes_include;
    logic [13:0] bipolar_threshold_sel, comparator_scan_enable, cell_fault_masked;
    logic [5:0] aux_pin_function_config, pin_io_mode_enable, aux_reference_select;
    int n_fail, checks_done;

    aux_result_polarity_cfg aux_result_polarity_cfg_inst (.ref_clk, .resetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .aux_result_valid, .aux_result_sel, .aux_result_skipped, .aux_channel_result,
        .aux_measure_enable, .aux_pin_function_config, .pin_io_mode_enable,
        .aux_reference_select, .balance_switch_diagnostic, .cell_fault_raw, .cell_bipolar,
        .extremes_include, .bipolar_threshold_sel, .comparator_scan_enable, .cell_fault_masked);
    ahb_host ahb_host_inst (.ref_clk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata);

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string w, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", w, exp, seen);
        end
    endtask

    function automatic logic [31:0] adr(input logic [7:0] idx);
        return {22'h000000, idx, 2'h0};
    endfunction

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        ahb_host_inst.xfer(1'b1, adr(idx), d, rd);
    endtask

    task automatic rdc(input string w, input logic [31:0] a, input logic [31:0] e);
        ahb_host_inst.xfer(1'b0, a, 32'h0, rd);
        chk(w, rd, e);
    endtask

    task automatic strobe(input logic ch, input logic skip, input logic [13:0] v);
        aux_result_valid <= 1'b1;
        aux_result_sel <= ch;
        aux_result_skipped <= skip;
        aux_channel_result <= v;
        @(posedge ref_clk);
        aux_result_valid <= 1'b0;
        aux_channel_result <= ~v;
        @(posedge ref_clk);
    endtask

    // Derived outputs lag by one edge; sample mid-cycle
    task automatic settle();
        repeat (2) @(negedge ref_clk);
    endtask

    task automatic t_reset();
        rdc("res4", adr(IDX_AUX_RESULT_CH4), 32'h0);
        rdc("res5", adr(IDX_AUX_RESULT_CH5), 32'h0);
        rdc("range", adr(IDX_CELL_RANGE_CTRL), 32'h0);
        rdc("ref", adr(IDX_AUX_REF_CTRL), 32'h0);
    endtask

    task automatic t_results();
        strobe(1'b0, 1'b0, 14'h3FFF);
        strobe(1'b1, 1'b0, 14'h0001);
        rdc("res4", adr(IDX_AUX_RESULT_CH4), 32'hFFFC);
        rdc("res5", adr(IDX_AUX_RESULT_CH5), 32'h0004);
        wr(IDX_AUX_RESULT_CH4, 32'h1234);
        rdc("res4 ro", adr(IDX_AUX_RESULT_CH4), 32'hFFFC);
        aux_measure_enable <= 1'b0;
        strobe(1'b0, 1'b1, 14'h0AAA);
        rdc("res4 kept", adr(IDX_AUX_RESULT_CH4), 32'hFFFC);
        strobe(1'b0, 1'b0, 14'h1555);
        rdc("res4 new", adr(IDX_AUX_RESULT_CH4), 32'h5554);
        aux_measure_enable <= 1'b1;
        strobe(1'b0, 1'b1, 14'h0FFF);
        rdc("res4 skip en", adr(IDX_AUX_RESULT_CH4), 32'h3FFC);
        aux_pin_function_config <= 6'h00;
        @(posedge ref_clk);
        rdc("res4 off", adr(IDX_AUX_RESULT_CH4), 32'h0);
        rdc("res5 off", adr(IDX_AUX_RESULT_CH5), 32'h0);
        aux_pin_function_config <= 6'h30;
        @(posedge ref_clk);
        rdc("res4 back", adr(IDX_AUX_RESULT_CH4), 32'h3FFC);
        rdc("res5 back", adr(IDX_AUX_RESULT_CH5), 32'h0004);
    endtask

    task automatic t_polarity();
        wr(IDX_CELL_RANGE_CTRL, 32'h0000D234);
        rdc("range", adr(IDX_CELL_RANGE_CTRL), 32'h9234);
        settle();
        chk("bipolar", cell_bipolar, 14'h1234);
        chk("extremes", extremes_include, 14'h1234);
        chk("thresh", bipolar_threshold_sel, 14'h1234);
        chk("comp", comparator_scan_enable, 14'h3FFF ^ 14'h1234);
        @(posedge ref_clk);
        cell_fault_raw <= 14'h3FFF;
        balance_switch_diagnostic <= 1'b1;
        wr(IDX_CELL_RANGE_CTRL, 32'h1234);
        settle();
        chk("extremes", extremes_include, 14'h3FFF ^ 14'h1234);
        chk("masked", cell_fault_masked, 14'h3FFF ^ 14'h1234);
        @(posedge ref_clk);
        balance_switch_diagnostic <= 1'b0;
        settle();
        chk("unmasked", cell_fault_masked, 14'h3FFF);
        @(posedge ref_clk);
    endtask

    task automatic t_refsel();
        wr(IDX_AUX_REF_CTRL, 32'hFFFF);
        rdc("ref", adr(IDX_AUX_REF_CTRL), 32'h003F);
        pin_io_mode_enable <= 6'h30;
        settle();
        chk("refsel", aux_reference_select, 6'h0F);
        @(posedge ref_clk);
        rdc("ref io", adr(IDX_AUX_REF_CTRL), 32'h003F);
        rdc("unmapped", 32'h00000184, 32'h0);
        rdc("misalign", adr(IDX_AUX_REF_CTRL) | 32'h1, 32'h0);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        n_fail++;
        report_and_stop();
    end

    initial begin
        resetn = 1'b0;
        aux_result_valid = 1'b0;
        aux_result_sel = 1'b0;
        aux_result_skipped = 1'b0;
        aux_channel_result = 14'h0;
        aux_measure_enable = 1'b1;
        aux_pin_function_config = 6'h30;
        pin_io_mode_enable = 6'h00;
        balance_switch_diagnostic = 1'b0;
        cell_fault_raw = 14'h0;
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_results();
        t_polarity();
        t_refsel();
        report_and_stop();
    end
endmodule

`default_nettype wire
